/* core/pcs_pkg.sv */
// constants and types shared by the sequencing core and its helpers
package pcs_pkg;
	localparam int PCS_PC_W    = 13;
	localparam int PCS_DEPTH   = 8;
	localparam int PCS_ADR_W   = 5;
	localparam int PCS_PORT_W  = 4;

	// register byte offsets on the bus
	localparam logic [PCS_ADR_W-1:0] PCS_REG_IRQ_CTRL = 5'h00;
	localparam logic [PCS_ADR_W-1:0] PCS_REG_PC_LOW   = 5'h04;
	localparam logic [PCS_ADR_W-1:0] PCS_REG_PC_HOLD  = 5'h08;
	localparam logic [PCS_ADR_W-1:0] PCS_REG_POINTER  = 5'h0C;

	// irq_control field positions, then the two page bits of the holding register
	localparam int PCS_GIE_BIT     = 7;
	localparam int PCS_NVM_EN_BIT  = 6;
	localparam int PCS_TMR_EN_BIT  = 5;
	localparam int PCS_EXT_EN_BIT  = 4;
	localparam int PCS_PORT_EN_BIT = 3;
	localparam int PCS_TMR_FLG_BIT = 2;
	localparam int PCS_EXT_FLG_BIT = 1;
	localparam int PCS_PORT_FLG_BIT = 0;
	localparam int PCS_PAGE_HI_BIT = 4;
	localparam int PCS_PAGE_LO_BIT = 3;

	// reset values, the interrupt vector and the counter step
	localparam logic [7:0]          PCS_IRQ_CTRL_RST = 8'h00;
	localparam logic [4:0]          PCS_PC_HOLD_RST  = 5'h00;
	localparam logic [7:0]          PCS_POINTER_RST  = 8'h00;
	localparam logic [PCS_PC_W-1:0] PCS_PC_RST       = 13'h0000;
	localparam logic [PCS_PC_W-1:0] PCS_IRQ_VECTOR   = 13'h0004;
	localparam logic [PCS_PC_W-1:0] PCS_PC_ONE       = 13'h0001;

	// file address of the indirect window, and the count that ends port-watch priming
	localparam logic [7:0] PCS_INDIRECT_ADDR = 8'h00;
	localparam logic [1:0] PCS_PRIME_DONE    = 2'h3;

	typedef enum logic [2:0] {
		PCS_OP_NONE,
		PCS_OP_STEP,
		PCS_OP_JUMP,
		PCS_OP_CALL,
		PCS_OP_RETURN,
		PCS_OP_RETURN_WITH_LITERAL,
		PCS_OP_RETURN_FROM_INTERRUPT,
		PCS_OP_IRQ_ACK
	} pcs_op_t;
endpackage : pcs_pkg

/* core/pcs_stack_if.sv */
// push and pop signals between the core and its return stack
`timescale 1ns/100ps
interface pcs_stack_if;
	import pcs_pkg::*;
	logic                push;
	logic                pop;
	logic [PCS_PC_W-1:0] push_data;
	logic [PCS_PC_W-1:0] top_data;
	modport core  (output push, output pop, output push_data, input top_data);
	modport store (input push, input pop, input push_data, output top_data);
endinterface : pcs_stack_if

/* core/pcs_ret_stack.sv */
// circular return stack with a hidden pointer
`timescale 1ns/100ps
module pcs_ret_stack
	import pcs_pkg::*;
#(
	parameter int DEPTH = PCS_DEPTH
) (
	input  wire logic   mclk,
	input  wire logic   reset,
	pcs_stack_if.store  stk
);
	localparam int PW = $clog2(DEPTH);
	logic [PCS_PC_W-1:0] mem [DEPTH];
	logic [PW-1:0]       ptr_q;
	logic [PW-1:0]       ptr_d;

	// [R14] pointer wraps silently
	always_comb begin
		ptr_d = ptr_q;
		if (stk.push) begin
			ptr_d = ptr_q + PW'(1);
		end else if (stk.pop) begin
			ptr_d = ptr_q - PW'(1);
		end
	end

	// [R11] storage outside all address spaces
	assign stk.top_data = mem[ptr_q - PW'(1)];

	always_ff @(posedge mclk) begin
		if (reset) begin
			ptr_q <= '0;
		end else begin
			ptr_q <= ptr_d;
		end
		if (stk.push) begin
			mem[ptr_q] <= stk.push_data;
		end
	end

	stack_lifo_a: assert property (@(posedge mclk) disable iff (reset) // [R12]
		stk.push && !stk.pop ##1 !stk.push && !stk.pop ##1 stk.pop |-> stk.top_data == $past(stk.push_data, 2))
		else $error("pop did not return the last pushed value");
	stack_wrap_a: assert property (@(posedge mclk) disable iff (reset) // [R15]
		stk.pop [*8] |=> ptr_q == $past(ptr_q, 8))
		else $error("stack pointer did not wrap after eight pops");
endmodule : pcs_ret_stack

/* core/pcs_port_watch.sv */
// synchronises the upper port pins and flags any change
`timescale 1ns/100ps
module pcs_port_watch
	import pcs_pkg::*;
#(
	parameter int WIDTH = PCS_PORT_W
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pins,
	output logic                  change
);
	logic [WIDTH-1:0] s1_q, s2_q, prev_q;
	logic [1:0]       prime_q, prime_d;
	logic             change_q, change_d;

	// the first samples after reset are not compared, so idle-high pins give no false event
	always_comb begin
		prime_d = (prime_q == PCS_PRIME_DONE) ? prime_q : prime_q + 2'h1;
		change_d = (prime_q == PCS_PRIME_DONE) && (s2_q != prev_q);
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q     <= '0;
			s2_q     <= '0;
			prev_q   <= '0;
			prime_q  <= 2'h0;
			change_q <= 1'b0;
		end else begin
			s1_q     <= pins;
			s2_q     <= s1_q;
			prev_q   <= s2_q;
			prime_q  <= prime_d;
			change_q <= change_d;
		end
	end

	assign change = change_q;
endmodule : pcs_port_watch

/* core/pcs_core.sv */
// program counter, return stack, interrupt control and indirect addressing core
`timescale 1ns/100ps
// Behaviour
// [R1] global enable gates every interrupt source
// [R2] bits 6..3 enable nvm, timer, pin, port
// [R3] timer flag set by overflow, software clears
// [R4] pin flag set on external pin event
// [R5] port flag set on upper pin change
// [R6] flags set regardless of any enable
// [R7] 13-bit counter, only low byte accessible
// [R8] loads take upper bits from holding register
// [R9] 11-bit target, page bits from holding
// [R10] software sets page bits before branching
// [R11] eight 13-bit entries, hidden pointer
// [R12] push on call/ack, pop on returns
// [R13] push and pop keep holding register
// [R14] ninth push overwrites first entry
// [R15] ninth pop equals the first pop
// [R16] no overflow or underflow indication
// [R17] indirect window accesses pointed register
// [R18] window through itself reads zero, ignores write
// [R19] effective address is bank bit plus pointer
// [R20] software minds 256-word table crossings
// [R21] counter steps by one, call pushes next
module pcs_core
	import pcs_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [PCS_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire pcs_op_t              exu_op,
	input  wire logic [10:0]          exu_target,
	input  wire logic                 exu_pcl_write,
	input  wire logic [7:0]           exu_pcl_data,
	input  wire logic                 fa_valid,
	input  wire logic                 fa_write,
	input  wire logic [7:0]           fa_addr,
	input  wire logic                 indirect_bank_select,
	input  wire logic                 timer_overflow,
	input  wire logic                 ext_pin_event,
	input  wire logic                 nvm_write_done,
	input  wire logic [PCS_PORT_W-1:0] upper_port_pins,
	output logic      [PCS_PC_W-1:0]  pc,
	output logic                      irq_request,
	output logic                      fa_out_valid,
	output logic      [8:0]           fa_eff_addr,
	output logic                      fa_eff_write,
	output logic                      fa_null_read
);
	logic [7:0]          irq_ctrl_q, irq_ctrl_d;
	logic [4:0]          pc_hold_q, pc_hold_d;
	logic [7:0]          pointer_q, pointer_d;
	logic [PCS_PC_W-1:0] pc_q, pc_d;
	logic [PCS_PC_W-1:0] branch_target;
	logic                irq_req_q, irq_req_d;
	logic                ack_q, ack_d;
	logic [31:0]         rdata_q, rdata_d;
	logic                fa_valid_q, fa_valid_d;
	logic [8:0]          eff_addr_q, eff_addr_d;
	logic                eff_we_q, eff_we_d;
	logic                null_q, null_d;
	logic                wb_req, wb_wr;
	logic                port_change;
	logic                ind_hit, ind_self;

	pcs_stack_if stk ();

	pcs_ret_stack #(.DEPTH(PCS_DEPTH)) u_stack (
		.mclk  (mclk),
		.reset (reset),
		.stk   (stk.store)
	);

	pcs_port_watch #(.WIDTH(PCS_PORT_W)) u_port (
		.mclk   (mclk),
		.reset  (reset),
		.pins   (upper_port_pins),
		.change (port_change)
	);

	// one-cycle answer; ack drops the cycle after it was given
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

	// [R9] page bits above the 11-bit target
	assign branch_target = {pc_hold_q[PCS_PAGE_HI_BIT:PCS_PAGE_LO_BIT], exu_target};

	always_comb begin
		ack_d   = wb_req;
		rdata_d = rdata_q;
		if (wb_req) begin
			rdata_d = 32'h0000_0000;
			case (wb_adr_i)
				PCS_REG_IRQ_CTRL: begin
					rdata_d[7:0] = irq_ctrl_q;
				end
				// [R7] only the low byte is visible
				PCS_REG_PC_LOW: begin
					rdata_d[7:0] = pc_q[7:0];
				end
				PCS_REG_PC_HOLD: begin
					rdata_d[4:0] = pc_hold_q;
				end
				PCS_REG_POINTER: begin
					rdata_d[7:0] = pointer_q;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_comb begin
		irq_ctrl_d = irq_ctrl_q;
		pc_hold_d  = pc_hold_q;
		pointer_d  = pointer_q;
		if (wb_wr) begin
			case (wb_adr_i)
				PCS_REG_IRQ_CTRL: begin
					irq_ctrl_d = wb_dat_i[7:0];
				end
				PCS_REG_PC_HOLD: begin
					pc_hold_d = wb_dat_i[4:0];
				end
				PCS_REG_POINTER: begin
					pointer_d = wb_dat_i[7:0];
				end
				default: begin
					pointer_d = pointer_q;
				end
			endcase
		end
		// [R6] events set flags after the clear, so a set wins
		// [R3] timer flag set here by overflow; otherwise only the bus write above changes it
		if (timer_overflow) begin
			irq_ctrl_d[PCS_TMR_FLG_BIT] = 1'b1;
		end
		// [R4] pin flag set on each pin event
		if (ext_pin_event) begin
			irq_ctrl_d[PCS_EXT_FLG_BIT] = 1'b1;
		end
		// [R5] port flag sticks until cleared
		if (port_change) begin
			irq_ctrl_d[PCS_PORT_FLG_BIT] = 1'b1;
		end
		// acknowledge masks further interrupts, return from interrupt re-opens them
		if (exu_op == PCS_OP_IRQ_ACK) begin
			irq_ctrl_d[PCS_GIE_BIT] = 1'b0;
		end else if (exu_op == PCS_OP_RETURN_FROM_INTERRUPT) begin
			irq_ctrl_d[PCS_GIE_BIT] = 1'b1;
		end
	end

	// [R1] global gate
	// [R2] per-source enables
	always_comb begin
		irq_req_d = irq_ctrl_q[PCS_GIE_BIT] && (
			(irq_ctrl_q[PCS_NVM_EN_BIT] && nvm_write_done) ||
			(irq_ctrl_q[PCS_TMR_EN_BIT] && irq_ctrl_q[PCS_TMR_FLG_BIT]) ||
			(irq_ctrl_q[PCS_EXT_EN_BIT] && irq_ctrl_q[PCS_EXT_FLG_BIT]) ||
			(irq_ctrl_q[PCS_PORT_EN_BIT] && irq_ctrl_q[PCS_PORT_FLG_BIT]));
	end

	// [R13] stack traffic never touches the holding register
	// [R16] no overflow or underflow status exists
	always_comb begin
		pc_d          = pc_q;
		stk.push      = 1'b0;
		stk.pop       = 1'b0;
		stk.push_data = pc_q + PCS_PC_ONE;
		case (exu_op)
			// [R21] sequential advance wraps in 13 bits
			PCS_OP_STEP: begin
				pc_d = pc_q + PCS_PC_ONE;
			end
			// [R8] absolute jump
			PCS_OP_JUMP: begin
				pc_d = branch_target;
			end
			// [R12] call pushes the return address
			PCS_OP_CALL: begin
				stk.push = 1'b1;
				pc_d     = branch_target;
			end
			// [R12] every return kind pops
			PCS_OP_RETURN, PCS_OP_RETURN_WITH_LITERAL, PCS_OP_RETURN_FROM_INTERRUPT: begin
				stk.pop = 1'b1;
				pc_d    = stk.top_data;
			end
			// acknowledge saves the not yet executed address
			PCS_OP_IRQ_ACK: begin
				stk.push      = 1'b1;
				stk.push_data = pc_q;
				pc_d          = PCS_IRQ_VECTOR;
			end
			default: begin
				// [R8] low-byte write takes upper bits from holding
				if (exu_pcl_write) begin
					pc_d = {pc_hold_q, exu_pcl_data};
				end else if (wb_wr && wb_adr_i == PCS_REG_PC_LOW) begin
					pc_d = {pc_hold_q, wb_dat_i[7:0]};
				end
			end
		endcase
	end

	// [R17] window has no storage, pointer supplies the address
	assign ind_hit  = fa_addr == PCS_INDIRECT_ADDR;
	// bank 1 mirrors the window, so only the low seven bits decide
	assign ind_self = ind_hit && (pointer_q[6:0] == PCS_INDIRECT_ADDR[6:0]);

	always_comb begin
		fa_valid_d = fa_valid;
		// [R19] bank bit above the 8-bit pointer
		eff_addr_d = ind_hit ? {indirect_bank_select, pointer_q} : {1'b0, fa_addr};
		// [R18] self-reference reads zero and writes nothing
		eff_we_d   = fa_valid && fa_write && !ind_self;
		null_d     = fa_valid && ind_self;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_ctrl_q <= PCS_IRQ_CTRL_RST;
			pc_hold_q  <= PCS_PC_HOLD_RST;
			pointer_q  <= PCS_POINTER_RST;
			pc_q       <= PCS_PC_RST;
			irq_req_q  <= 1'b0;
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			fa_valid_q <= 1'b0;
			eff_addr_q <= 9'h000;
			eff_we_q   <= 1'b0;
			null_q     <= 1'b0;
		end else begin
			irq_ctrl_q <= irq_ctrl_d;
			pc_hold_q  <= pc_hold_d;
			pointer_q  <= pointer_d;
			pc_q       <= pc_d;
			irq_req_q  <= irq_req_d;
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
			fa_valid_q <= fa_valid_d;
			eff_addr_q <= eff_addr_d;
			eff_we_q   <= eff_we_d;
			null_q     <= null_d;
		end
	end

	assign wb_dat_o     = rdata_q;
	assign wb_ack_o     = ack_q;
	assign pc           = pc_q;
	assign irq_request  = irq_req_q;
	assign fa_out_valid = fa_valid_q;
	assign fa_eff_addr  = eff_addr_q;
	assign fa_eff_write = eff_we_q;
	assign fa_null_read = null_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	gie_gate_a: assert property (!irq_ctrl_q[PCS_GIE_BIT] |=> !irq_req_q) // [R1]
		else $error("interrupt requested with global enable clear");
	timer_irq_a: assert property (irq_ctrl_q[PCS_GIE_BIT] && irq_ctrl_q[PCS_TMR_EN_BIT] // [R2]
		&& irq_ctrl_q[PCS_TMR_FLG_BIT] |=> irq_req_q)
		else $error("enabled timer flag gave no request");
	timer_hold_a: assert property (irq_ctrl_q[PCS_TMR_FLG_BIT] // [R3]
		&& !(wb_wr && wb_adr_i == PCS_REG_IRQ_CTRL) |=> irq_ctrl_q[PCS_TMR_FLG_BIT])
		else $error("timer flag cleared by hardware");
	pin_flag_a: assert property (ext_pin_event |=> irq_ctrl_q[PCS_EXT_FLG_BIT]) // [R4]
		else $error("pin event did not set its flag");
	port_flag_a: assert property (port_change ##1 !(wb_wr && wb_adr_i == PCS_REG_IRQ_CTRL) // [R5]
		|=> irq_ctrl_q[PCS_PORT_FLG_BIT])
		else $error("port flag lost before software cleared it");
	jump_page_a: assert property (exu_op == PCS_OP_JUMP // [R9]
		|=> pc_q == {$past(pc_hold_q[PCS_PAGE_HI_BIT:PCS_PAGE_LO_BIT]), $past(exu_target)})
		else $error("jump target or page bits wrong");
	pcl_load_a: assert property (exu_op == PCS_OP_NONE && exu_pcl_write // [R8]
		|=> pc_q == {$past(pc_hold_q), $past(exu_pcl_data)})
		else $error("low-byte write did not load upper bits");
	call_push_a: assert property (exu_op == PCS_OP_CALL // [R21]
		|-> stk.push && stk.push_data == pc_q + PCS_PC_ONE)
		else $error("call pushed the wrong address");
	hold_keep_a: assert property ((stk.push || stk.pop) && !wb_wr |=> $stable(pc_hold_q)) // [R13]
		else $error("holding register changed by stack traffic");
	step_pc_a: assert property (exu_op == PCS_OP_STEP |=> pc_q == $past(pc_q) + PCS_PC_ONE) // [R21]
		else $error("sequential step wrong");
	ind_null_a: assert property (fa_valid && ind_self |=> fa_null_read && !fa_eff_write) // [R18]
		else $error("self-referencing indirect access not suppressed");
	wb_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle");
	ret_pop_a: assert property (exu_op inside {PCS_OP_RETURN, PCS_OP_RETURN_WITH_LITERAL, PCS_OP_RETURN_FROM_INTERRUPT} // [R12]
		|-> stk.pop && !stk.push)
		else $error("return did not pop the stack");
	ret_load_a: assert property (stk.pop |=> pc_q == $past(stk.top_data)) // [R12]
		else $error("return did not load the popped address");
	ack_push_a: assert property (exu_op == PCS_OP_IRQ_ACK |-> stk.push && stk.push_data == pc_q) // [R12]
		else $error("acknowledge pushed the wrong address");
	ack_vector_a: assert property (exu_op == PCS_OP_IRQ_ACK
		|=> pc_q == PCS_IRQ_VECTOR && !irq_ctrl_q[PCS_GIE_BIT])
		else $error("acknowledge did not vector or mask");
	call_page_a: assert property (exu_op == PCS_OP_CALL // [R8]
		|=> pc_q == {$past(pc_hold_q[PCS_PAGE_HI_BIT:PCS_PAGE_LO_BIT]), $past(exu_target)})
		else $error("call target or page bits wrong");
	bus_pcl_a: assert property (wb_wr && wb_adr_i == PCS_REG_PC_LOW // [R8]
		&& exu_op == PCS_OP_NONE && !exu_pcl_write |=> pc_q == {$past(pc_hold_q), $past(wb_dat_i[7:0])})
		else $error("bus low-byte write did not load upper bits");
	pc_keep_a: assert property (exu_op == PCS_OP_NONE && !exu_pcl_write // [R7]
		&& !(wb_wr && wb_adr_i == PCS_REG_PC_LOW) |=> $stable(pc_q))
		else $error("counter moved without a load or step");
	pcl_read_a: assert property (wb_req && !wb_we_i && wb_adr_i == PCS_REG_PC_LOW // [R7]
		|=> wb_dat_o == {24'h000000, $past(pc_q[7:0])})
		else $error("low-byte read wrong");
	ext_irq_a: assert property (irq_ctrl_q[PCS_GIE_BIT] && irq_ctrl_q[PCS_EXT_EN_BIT] // [R2]
		&& irq_ctrl_q[PCS_EXT_FLG_BIT] |=> irq_req_q)
		else $error("enabled pin flag gave no request");
	port_irq_a: assert property (irq_ctrl_q[PCS_GIE_BIT] && irq_ctrl_q[PCS_PORT_EN_BIT] // [R2]
		&& irq_ctrl_q[PCS_PORT_FLG_BIT] |=> irq_req_q)
		else $error("enabled port flag gave no request");
	nvm_irq_a: assert property (irq_ctrl_q[PCS_GIE_BIT] && irq_ctrl_q[PCS_NVM_EN_BIT] // [R2]
		&& nvm_write_done |=> irq_req_q)
		else $error("enabled write-done gave no request");
	mask_irq_a: assert property (irq_ctrl_q[PCS_NVM_EN_BIT:PCS_PORT_EN_BIT] == 4'h0 |=> !irq_req_q) // [R2]
		else $error("request raised with every source disabled");
	flag_free_a: assert property (timer_overflow |=> irq_ctrl_q[PCS_TMR_FLG_BIT]) // [R6]
		else $error("timer flag not set by its event");
	port_set_a: assert property (port_change |=> irq_ctrl_q[PCS_PORT_FLG_BIT]) // [R5]
		else $error("port change did not set its flag");
	ind_addr_a: assert property (fa_valid && ind_hit // [R19]
		|=> fa_eff_addr == {$past(indirect_bank_select), $past(pointer_q)})
		else $error("indirect effective address wrong");
	ind_write_a: assert property (fa_valid && fa_write && !ind_self |=> fa_eff_write) // [R17]
		else $error("file write through the window lost");

	call_ret_c: cover property (exu_op == PCS_OP_CALL ##[1:20] exu_op == PCS_OP_RETURN);
	irq_ack_c: cover property (irq_req_q ##[1:10] exu_op == PCS_OP_IRQ_ACK);
	ind_null_c: cover property (fa_valid && ind_self);
	wb_write_c: cover property (wb_wr && wb_adr_i == PCS_REG_PC_LOW);
	ring_wrap_c: cover property (stk.pop [*8]);
endmodule : pcs_core

/* testbench/pcs_exu_model.sv */
// execution unit model: issues sequencing ops, low-byte writes and file accesses
`timescale 1ns/100ps
module pcs_exu_model
	import pcs_pkg::*;
(
	input  wire logic  mclk,
	output pcs_op_t    exu_op,
	output logic [10:0] exu_target,
	output logic       exu_pcl_write,
	output logic [7:0] exu_pcl_data,
	output logic       fa_valid,
	output logic       fa_write,
	output logic [7:0] fa_addr,
	output logic       indirect_bank_select
);
	initial begin
		exu_op = PCS_OP_NONE;
		exu_target = 11'h000;
		exu_pcl_write = 1'b0;
		exu_pcl_data = 8'h00;
		fa_valid = 1'b0;
		fa_write = 1'b0;
		fa_addr = 8'h00;
		indirect_bank_select = 1'b0;
	end

	// caller sets page bits first; released target is inverted, not left stale
	task op(input pcs_op_t o, input logic [10:0] t);
		@(posedge mclk);
		exu_op <= o;
		exu_target <= t;
		@(posedge mclk);
		exu_op <= PCS_OP_NONE;
		exu_target <= ~t;
		#1;
	endtask : op

	// back-to-back ops: the same op stands for n cycles
	task run(input pcs_op_t o, input int n);
		@(posedge mclk);
		exu_op <= o;
		repeat (n) @(posedge mclk);
		exu_op <= PCS_OP_NONE;
		#1;
	endtask : run

	// writes the low byte outright; a table crossing a 256-word block is left to the caller
	task pc_low_byte(input logic [7:0] d);
		@(posedge mclk);
		exu_pcl_write <= 1'b1;
		exu_pcl_data <= d;
		@(posedge mclk);
		exu_pcl_write <= 1'b0;
		exu_pcl_data <= ~d;
		#1;
	endtask : pc_low_byte

	task fa(input logic w, input logic [7:0] a, input logic b);
		@(posedge mclk);
		fa_valid <= 1'b1;
		fa_write <= w;
		fa_addr <= a;
		indirect_bank_select <= b;
		@(posedge mclk);
		fa_valid <= 1'b0;
		fa_write <= ~w;
		fa_addr <= ~a;
		indirect_bank_select <= ~b;
		#1;
	endtask : fa
endmodule : pcs_exu_model

/* testbench/test_core_pc_stack_indirect_irq_ctrl.sv */
// self-checking bench for the sequencing and addressing core
`timescale 1ns/100ps
module test_core_pc_stack_indirect_irq_ctrl
	import pcs_pkg::*;
;
	logic                  mclk, reset, wb_cyc, wb_stb, wb_we, wb_ack_o;
	logic [PCS_ADR_W-1:0]  wb_adr;
	logic [3:0]            wb_sel, wsel;
	logic [31:0]           wb_dat, wb_dat_o, q;
	pcs_op_t               exu_op;
	logic [10:0]           exu_target;
	logic                  exu_pcl_write, fa_valid, fa_write, bank, irq;
	logic [7:0]            exu_pcl_data, fa_addr;
	logic [2:0]            ev;
	logic [PCS_PORT_W-1:0] pins;
	logic [PCS_PC_W-1:0]   pc, epc;
	logic [PCS_PC_W-1:0]   stk [8];
	logic                  fo_valid, fo_write, fo_null;
	logic [8:0]            fo_addr;
	int                    sp, n_fail, samples_checked;

	pcs_core dut (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.exu_op(exu_op), .exu_target(exu_target), .exu_pcl_write(exu_pcl_write), .exu_pcl_data(exu_pcl_data),
		.fa_valid(fa_valid), .fa_write(fa_write), .fa_addr(fa_addr), .indirect_bank_select(bank),
		.timer_overflow(ev[0]), .ext_pin_event(ev[1]), .nvm_write_done(ev[2]), .upper_port_pins(pins),
		.pc(pc), .irq_request(irq), .fa_out_valid(fo_valid), .fa_eff_addr(fo_addr),
		.fa_eff_write(fo_write), .fa_null_read(fo_null));

	pcs_exu_model u_exu (.mclk(mclk), .exu_op(exu_op), .exu_target(exu_target), .exu_pcl_write(exu_pcl_write),
		.exu_pcl_data(exu_pcl_data), .fa_valid(fa_valid), .fa_write(fa_write), .fa_addr(fa_addr),
		.indirect_bank_select(bank));

	task end_of_test;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	// the slave answers in its own time; the ack or the bound of 20 cycles ends a wait
	task wb(input logic we, input logic [PCS_ADR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, wsel, 24'h000000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("MISMATCH %0t no bus answer", $time);
		end
		q = wb_dat_o;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
		#1;
	endtask : wb

	task evp(input logic [2:0] v, input logic [3:0] p);
		@(posedge mclk);
		ev <= v;
		pins <= p;
		@(posedge mclk);
		ev <= v & 3'h4;
		tick(6);
	endtask : evp

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (3000) @(posedge mclk);
		n_fail++;
		$display("MISMATCH %0t watchdog", $time);
		end_of_test;
	end

	initial begin
		{reset, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, ev, pins} = '0;
		reset = 1'b1;
		wb_sel = 4'hF;
		wsel = 4'hF;
		{n_fail, samples_checked, sp} = {32'h0, 32'h0, 32'h20};
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		// all four registers and an unmapped place read zero after reset
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, 5'(i * 4), 8'h00);
			cmp(q, 32'h0);
		end
		cmp(pc, PCS_PC_RST);
		wb(1'b1, PCS_REG_PC_HOLD, 8'hFF);
		wb(1'b1, PCS_REG_POINTER, 8'hA5);
		// lane 0 disabled: the write is answered but lost
		wsel = 4'hE;
		wb(1'b1, PCS_REG_POINTER, 8'h11);
		wsel = 4'hF;
		wb(1'b0, PCS_REG_POINTER, 8'h00);
		cmp(q, 32'hA5);
		wb(1'b1, 5'h10, 8'hFF);
		wb(1'b0, 5'h10, 8'h00);
		cmp(q, 32'h0);
		wb(1'b1, PCS_REG_PC_LOW, 8'hFF);
		cmp(pc, 13'h1FFF);
		wb(1'b0, PCS_REG_PC_LOW, 8'h00);
		cmp(q, 32'hFF);
		u_exu.op(PCS_OP_STEP, 11'h000);
		cmp(pc, 13'h0000);
		u_exu.op(PCS_OP_JUMP, 11'h123);
		cmp(pc, 13'h1923);
		u_exu.pc_low_byte(8'h40);
		cmp(pc, 13'h1F40);
		u_exu.op(PCS_OP_CALL, 11'h0AA);
		cmp(pc, 13'h18AA);
		u_exu.op(PCS_OP_RETURN, 11'h000);
		cmp(pc, 13'h1F41);
		// ten calls then ten returns: the pointer wraps silently both ways
		epc = 13'h1F41;
		for (int i = 0; i < 10; i++) begin
			stk[sp % 8] = epc + PCS_PC_ONE;
			sp++;
			epc = {2'b11, 11'(i * 100 + 7)};
			u_exu.op(PCS_OP_CALL, epc[10:0]);
			cmp(pc, epc);
		end
		for (int i = 0; i < 10; i++) begin
			sp--;
			epc = stk[sp % 8];
			u_exu.op(i[0] ? PCS_OP_RETURN_WITH_LITERAL : PCS_OP_RETURN, 11'h000);
			cmp(pc, epc);
		end
		// nine pops back to back: the last returns what the first did
		epc = stk[7];
		u_exu.run(PCS_OP_RETURN, 9);
		cmp(pc, epc);
		wb(1'b0, PCS_REG_PC_HOLD, 8'h00);
		cmp(q, 32'h1F);
		// flags set with every enable off, and raise no request
		evp(3'b111, 4'hA);
		wb(1'b0, PCS_REG_IRQ_CTRL, 8'h00);
		cmp({irq, q[7:0]}, 9'h007);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, PCS_REG_IRQ_CTRL, 8'h87 | (8'h08 << k));
			tick(2);
			cmp(irq, 1'b1);
		end
		wb(1'b1, PCS_REG_IRQ_CTRL, 8'h87);
		tick(2);
		cmp(irq, 1'b0);
		wb(1'b1, PCS_REG_IRQ_CTRL, 8'h7F);
		tick(2);
		cmp(irq, 1'b0);
		wb(1'b1, PCS_REG_IRQ_CTRL, 8'h00);
		wb(1'b0, PCS_REG_IRQ_CTRL, 8'h00);
		cmp(q, 32'h0);
		wb(1'b1, PCS_REG_IRQ_CTRL, 8'hA0);
		evp(3'b101, 4'hA);
		cmp(irq, 1'b1);
		u_exu.op(PCS_OP_IRQ_ACK, 11'h000);
		cmp(pc, PCS_IRQ_VECTOR);
		wb(1'b0, PCS_REG_IRQ_CTRL, 8'h00);
		cmp(q, 32'h24);
		u_exu.op(PCS_OP_RETURN_FROM_INTERRUPT, 11'h000);
		cmp(pc, epc);
		wb(1'b0, PCS_REG_IRQ_CTRL, 8'h00);
		cmp(q, 32'hA4);
		// indirect access goes to the pointed register, never to the window itself
		wb(1'b1, PCS_REG_POINTER, 8'h05);
		u_exu.fa(1'b0, 8'h00, 1'b1);
		cmp({fo_valid, fo_null, fo_addr}, {2'b10, 9'h105});
		u_exu.fa(1'b1, 8'h00, 1'b0);
		cmp({fo_write, fo_addr}, {1'b1, 9'h005});
		u_exu.fa(1'b1, 8'h0C, 1'b1);
		cmp({fo_write, fo_null, fo_addr}, {2'b10, 9'h00C});
		wb(1'b1, PCS_REG_POINTER, 8'h00);
		u_exu.fa(1'b1, 8'h00, 1'b0);
		cmp(fo_write, 1'b0);
		u_exu.fa(1'b0, 8'h00, 1'b0);
		cmp({fo_valid, fo_null}, 2'b11);
		end_of_test;
	end
endmodule : test_core_pc_stack_indirect_irq_ctrl
